// ===== src/vrls_pkg.sv
// Shared constants for the video memory row load sequencer.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package vrls_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADR_W = 11;                     // Byte address width
  localparam int DAT_W = 32;                     // Data width
  localparam int SEL_W = 4;                      // Byte lane count
  localparam logic [ADR_W-1:0] OFS_TT_CYCLE = 11'h000; // Timing-table cycle
  localparam logic [ADR_W-1:0] OFS_STATUS   = 11'h004; // Status, read only
  localparam logic       WIN_ROWLOAD  = 1'b1;    // adr[10] set: row-load window
  localparam int         WIN_BIT      = 10;      // Window select bit
  localparam int         ROW_LSB      = 2;       // Row number starts at adr[2]

  // ----------------------------------------------------------------
  // Row and pixel geometry
  // ----------------------------------------------------------------
  localparam int ROW_W    = 8;                   // 256 rows
  localparam int LVL_W    = 8;                   // Exposure and luminance width
  localparam int CNT_W    = 8;                   // Pixel counter width
  localparam logic [CNT_W-1:0] CNT_LAST = 8'hff; // 256 shift clocks per block
  localparam int PIX_PER_SC = 2;                 // Two pixels per shift clock
  localparam logic [ROW_W-1:0] COL_ZERO = 8'h00; // Column for every transfer

  // ----------------------------------------------------------------
  // Midline load select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_REFRESH = 2'b00;    // No load, refresh only
  localparam logic [1:0] SEL_MID1    = 2'b01;    // Row bit 0 set
  localparam logic [1:0] SEL_MID2    = 2'b10;    // Row bits 1:0 = 10
  localparam logic [1:0] SEL_MID3    = 2'b11;    // Row bits 1:0 = 11

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ST_ROW = 0;                     // Last DMA row
  localparam int ST_LVL = 8;                     // Exposure level
  localparam int ST_LUM = 16;                    // Luminance level
  localparam int ST_CNT = 24;                    // Pixel counter

  // Bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_REG   = 3'b001,
    ST_TRG   = 3'b010,
    ST_RAS   = 3'b011,
    ST_MID   = 3'b100,
    ST_REF   = 3'b101
  } vrls_state_e;

endpackage : vrls_pkg

// ===== src/vrls_pixel_counter.sv
// Pixel counter clocked by sampled shift clock edges.
// Assumes shift_edge is a one-cycle pulse per serial shift clock rise.
`timescale 1ns/10ps
`default_nettype none
module vrls_pixel_counter
  import vrls_pkg::*;
#(
  parameter int W = CNT_W
)(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         restart,
  input  wire logic         shift_edge,
  output logic [W-1:0]      count,
  output logic              expire
);
  import vrls_pkg::*;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [W-1:0] count_reg;                // Shift clocks seen in this block
  logic [W-1:0] count_next;

  // Expiry is the last shift of the block: the register empties now
  assign expire     = shift_edge && (count_reg == CNT_LAST);
  // Restart wins so a fresh load always starts a full block
  assign count_next = restart    ? '0 :
                      shift_edge ? count_reg + 1'b1 : count_reg;
  assign count      = count_reg;

  // Count register, wraps naturally after the last shift
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule : vrls_pixel_counter
`default_nettype wire

// ===== src/vrls_row_load_seq.sv
// Video memory row load sequencer: row loads, midline loads, levels.
// Assumes a classic Wishbone master and a shift clock synchronous to core_clk.
//
// Behaviour
// (R01) DMA counts one transfer per scan line
// (R02) Row-load write pulses the row load strobe
// (R03) Row number comes from eight address lines
// (R04) Low data byte becomes exposure level
// (R05) High data byte becomes luminance level
// (R06) DMA does exactly one transfer per line
// (R07) Handler reloads DMA for next level
// (R08) Two pixels per shift clock, 512-pixel blocks
// (R09) First load runs before shift clock starts
// (R10) Next block loads as last pixel leaves
// (R11) Software aligns buffers so row bit zero
// (R12) Midline load waits for block end
// (R13) 256-count pixel counter ends midline cycle
// (R14) Three midline loads reach 2K-wide images
// (R15) Select 00 gives refresh, no load
// (R16) Select 01: upper seven bits, bit0 one
// (R17) Select 10: upper six bits, bits 10
// (R18) Select 11: upper six bits, bits 11
// (R19) Transfer strobe before row strobe, column zero
// (R20) Comparator high when pixel at least level
// (R21) Bus ready held until counter expires
`timescale 1ns/10ps
`default_nettype none
module vrls_row_load_seq
  import vrls_pkg::*;
#(
  parameter int NPIX = PIX_PER_SC
)(
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [vrls_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [vrls_pkg::SEL_W-1:0] wb_sel_i,
  input  wire logic [vrls_pkg::DAT_W-1:0] wb_dat_i,
  output logic [vrls_pkg::DAT_W-1:0]      wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    serial_shift_clock,
  input  wire logic [NPIX*vrls_pkg::LVL_W-1:0] pixel_bytes,
  output logic                         row_load_strobe,
  output logic                         vram_transfer_strobe,
  output logic                         cbr_refresh_strobe,
  output logic [vrls_pkg::ROW_W-1:0]      vram_row_addr,
  output logic [vrls_pkg::ROW_W-1:0]      vram_col_addr,
  output logic [vrls_pkg::LVL_W-1:0]      exposure_level,
  output logic [vrls_pkg::LVL_W-1:0]      luminance_level,
  output logic [NPIX-1:0]              video_bits
);
  import vrls_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Row for a midline load from the last DMA row and the select code
  function automatic logic [ROW_W-1:0] mid_row(
    input logic [ROW_W-1:0] base,
    input logic [1:0]       sel
  );
    logic [ROW_W-1:0] r;
    r = base;
    unique case (sel)
      SEL_MID1: r = {base[ROW_W-1:1], 1'b1};          // [R16]
      SEL_MID2: r = {base[ROW_W-1:2], 2'b10};         // [R17]
      SEL_MID3: r = {base[ROW_W-1:2], 2'b11};         // [R18]
      SEL_REFRESH: r = base;
    endcase
    return r;                                         // [R14]
  endfunction : mid_row

  // Comparator: pixel at or above the exposure level lights the beam
  function automatic logic at_level(
    input logic [LVL_W-1:0] pix,
    input logic [LVL_W-1:0] lvl
  );
    return pix >= lvl;                                // [R20]
  endfunction : at_level

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vrls_state_e      state_reg;          // Bus sequencer state
  vrls_state_e      state_next;
  logic [ROW_W-1:0] last_row_reg;       // Row of the latest DMA load
  logic [ROW_W-1:0] row_reg;            // Row presented to the memories
  logic [ROW_W-1:0] row_next;
  logic [LVL_W-1:0] level_reg;          // Comparator latch
  logic [LVL_W-1:0] lum_reg;            // Luminance latch
  logic [1:0]       sel_reg;            // Last timing-table select code
  logic [DAT_W-1:0] rdata_reg;          // Registered read data
  logic [NPIX-1:0]  video_reg;          // Comparator outputs
  logic             sc_prev_reg;        // Shift clock, one cycle late
  logic             shift_edge;         // Rising shift clock edge
  logic [CNT_W-1:0] pix_count;          // Pixel counter value
  logic             pix_expire;         // Block fully shifted out

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire req        = wb_cyc_i && wb_stb_i;
  wire idle       = (state_reg == ST_IDLE);
  wire take       = idle && req;
  wire in_window  = (wb_adr_i[WIN_BIT] == WIN_ROWLOAD);
  wire hit_tt     = !in_window && (wb_adr_i == OFS_TT_CYCLE);
  wire hit_status = !in_window && (wb_adr_i == OFS_STATUS);
  // A row-load write is the DMA channel's once-per-line transfer
  wire dma_req    = take && wb_we_i && in_window;                // [R02]
  // Row number rides on the eight address lines above the byte lanes
  wire [ROW_W-1:0] dma_row = wb_adr_i[ROW_LSB +: ROW_W];         // [R03]
  wire tt_req     = take && wb_we_i && hit_tt;
  wire [1:0] tt_sel = wb_dat_i[1:0];
  wire mid_req    = tt_req && (tt_sel != SEL_REFRESH);           // [R12]
  wire ref_req    = tt_req && (tt_sel == SEL_REFRESH);           // [R15]

  // ----------------------------------------------------------------
  // Shift clock edge
  // ----------------------------------------------------------------
  // The shift clock is sampled as a plain synchronous input
  assign shift_edge = serial_shift_clock && !sc_prev_reg;

  // Previous shift clock level
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sc_prev_reg <= 1'b0;
    else
      sc_prev_reg <= serial_shift_clock;
  end

  // Counter restarts on every DMA load; the first block of a line is
  // loaded while the shift clock is still, so counting starts fresh.
  vrls_pixel_counter #(
    .W          (CNT_W)
  ) u_pix_cnt (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .restart    (dma_req),                                      // [R09]
    .shift_edge (shift_edge),                                   // [R13]
    .count      (pix_count),
    .expire     (pix_expire)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        // DMA load ignores the shift clock entirely
        if (dma_req)
          state_next = ST_TRG;                                   // [R09]
        else if (mid_req)
          state_next = ST_MID;
        else if (ref_req)
          state_next = ST_REF;
        else if (take)
          state_next = ST_REG;
      end
      ST_TRG:
        state_next = ST_RAS;                                     // [R19]
      ST_RAS, ST_REG, ST_REF:
        state_next = ST_IDLE;
      ST_MID:
      begin
        // Held until the last pixel of the block leaves
        if (pix_expire)
          state_next = ST_IDLE;                                  // [R10]
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Row register: DMA row, or the row derived for a midline load
  assign row_next = dma_req ? dma_row :
                    mid_req ? mid_row(last_row_reg, tt_sel) :    // [R14]
                    row_reg;

  // ----------------------------------------------------------------
  // Strobes and acknowledge
  // ----------------------------------------------------------------
  // Transfer strobe leads the row strobe so the memories see a load,
  // not a read, and it stays up through the row strobe.
  assign vram_transfer_strobe = (state_reg == ST_TRG) ||
                                (state_reg == ST_RAS) ||
                                (state_reg == ST_MID);           // [R19]
  // Row strobe: end of a DMA load, or exactly at block expiry
  assign row_load_strobe = (state_reg == ST_RAS) ||
                           ((state_reg == ST_MID) && pix_expire); // [R10]
  assign cbr_refresh_strobe = (state_reg == ST_REF);            // [R15]
  // Ready is withheld in the midline wait and released on expiry
  assign wb_ack_o = (state_reg == ST_RAS) ||
                    (state_reg == ST_REG) ||
                    (state_reg == ST_REF) ||
                    ((state_reg == ST_MID) && pix_expire);      // [R21]
  assign vram_col_addr = COL_ZERO;                              // [R19]
  assign vram_row_addr = row_reg;
  assign exposure_level  = level_reg;
  assign luminance_level = lum_reg;
  assign video_bits      = video_reg;
  assign wb_dat_o        = rdata_reg;

  // ----------------------------------------------------------------
  // State and row registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      row_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      row_reg   <= row_next;
    end
  end

  // ----------------------------------------------------------------
  // Latches written by the row-load transfer
  // ----------------------------------------------------------------
  // Software keeps wide buffers 1K-aligned, so row bit 0 arrives clear
  // and the midline codes only ever set bits.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      last_row_reg <= '0;
      level_reg    <= '0;
      lum_reg      <= '0;
    end
    else if (dma_req)
    begin
      last_row_reg <= dma_row;                                  // [R11]
      if (wb_sel_i[0])
        level_reg <= wb_dat_i[ST_LVL-1:0];                      // [R04]
      if (wb_sel_i[1])
        lum_reg   <= wb_dat_i[ST_LUM-1:ST_LVL];                 // [R05]
    end
  end

  // Last timing-table select code, kept for reads of the timing-table offset
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sel_reg <= SEL_REFRESH;
    else if (tt_req && wb_sel_i[0])
      sel_reg <= tt_sel;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped and write-only offsets read as zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= '0;
    else if (take && !wb_we_i)
    begin
      if (hit_status)
        rdata_reg <= {pix_count, lum_reg, level_reg, last_row_reg};
      else if (hit_tt)
        rdata_reg <= {{(DAT_W-2){1'b0}}, sel_reg};
      else
        rdata_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // One comparator per pixel shifted out in parallel
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      video_reg <= '0;
    else
      for (int i = 0; i < NPIX; i++)
        video_reg[i] <= at_level(pixel_bytes[i*LVL_W +: LVL_W],
                                 level_reg);                    // [R08]
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_dma_load;
    vram_transfer_strobe && !row_load_strobe
    ##1 row_load_strobe && vram_transfer_strobe && wb_ack_o;
  endsequence

  property p_dma_load;
    @(posedge core_clk) disable iff (!rstn)
    dma_req |-> ##1 s_dma_load;
  endproperty
  a_dma_load: assert property (p_dma_load) // [R02]
    else $error("row load write did not strobe in two cycles");

  property p_dma_row;
    @(posedge core_clk) disable iff (!rstn)
    dma_req |-> ##2 (vram_row_addr == $past(dma_row, 2));
  endproperty
  a_dma_row: assert property (p_dma_row) // [R03]
    else $error("row address differs from address lines");

  property p_level;
    @(posedge core_clk) disable iff (!rstn)
    dma_req && wb_sel_i[0] |=> exposure_level == $past(wb_dat_i[7:0]);
  endproperty
  a_level: assert property (p_level) // [R04]
    else $error("exposure level not taken from low byte");

  property p_lum;
    @(posedge core_clk) disable iff (!rstn)
    dma_req && wb_sel_i[1] |=> luminance_level == $past(wb_dat_i[15:8]);
  endproperty
  a_lum: assert property (p_lum) // [R05]
    else $error("luminance not taken from high byte");

  property p_trg_first;
    @(posedge core_clk) disable iff (!rstn)
    $rose(row_load_strobe) |-> $past(vram_transfer_strobe) &&
                              vram_col_addr == '0;
  endproperty
  a_trg_first: assert property (p_trg_first) // [R19]
    else $error("row strobe rose without transfer strobe lead");

  property p_mid_hold;
    @(posedge core_clk) disable iff (!rstn)
    (state_reg == ST_MID) && !pix_expire |-> !wb_ack_o && !row_load_strobe;
  endproperty
  a_mid_hold: assert property (p_mid_hold) // [R12]
    else $error("midline cycle ended before block end");

  property p_mid_end;
    @(posedge core_clk) disable iff (!rstn)
    (state_reg == ST_MID) && shift_edge && pix_count == CNT_LAST
      |-> wb_ack_o && row_load_strobe ##1 idle;
  endproperty
  a_mid_end: assert property (p_mid_end) // [R21]
    else $error("ready not released at counter expiry");

  property p_mid_row;
    @(posedge core_clk) disable iff (!rstn)
    mid_req |=> vram_row_addr ==
      mid_row($past(last_row_reg), $past(tt_sel));
  endproperty
  a_mid_row: assert property (p_mid_row) // [R16]
    else $error("midline row bits wrong");

  property p_refresh;
    @(posedge core_clk) disable iff (!rstn)
    ref_req |=> cbr_refresh_strobe && wb_ack_o && !row_load_strobe;
  endproperty
  a_refresh: assert property (p_refresh) // [R15]
    else $error("select 00 did not refresh");

  property p_compare;
    @(posedge core_clk) disable iff (!rstn)
    rstn |=> video_bits[0] ==
      ($past(pixel_bytes[7:0]) >= $past(exposure_level));
  endproperty
  a_compare: assert property (p_compare) // [R20]
    else $error("comparator output wrong");

endmodule : vrls_row_load_seq
`default_nettype wire

// ===== test/vrls_dma_model.sv
// DMA channel model: drives the block's Wishbone port, one transfer per line.
// Assumes a classic slave, possibly with wait states, that acks once for each request.
`timescale 1ns/10ps
`default_nettype none
module vrls_dma_model (
  input  wire logic                       core_clk,
  output logic                            wb_cyc_o,
  output logic                            wb_stb_o,
  output logic                            wb_we_o,
  output logic [vrls_pkg::ADR_W-1:0]      wb_adr_o,
  output logic [vrls_pkg::SEL_W-1:0]      wb_sel_o,
  output logic [vrls_pkg::DAT_W-1:0]      wb_dat_o,
  input  wire logic                       wb_ack_i,
  input  wire logic [vrls_pkg::DAT_W-1:0] wb_dat_i,
  output logic                            level_irq
);
  import vrls_pkg::*;
  // ----------------------------------------------------------------
  // State of the channel
  // ----------------------------------------------------------------
  int lines_left;                         // Lines still owed to this level
  initial
  begin
    wb_cyc_o  = 1'b0;
    wb_stb_o  = 1'b0;
    wb_we_o   = 1'b0;
    wb_adr_o  = '0;
    wb_sel_o  = '0;
    wb_dat_o  = '0;
    level_irq = 1'b0;
    lines_left = 0;
  end
  // One classic cycle; request held until ack is seen at a rising edge
  task automatic bus(input logic we, input logic [ADR_W-1:0] adr,
                     input logic [DAT_W-1:0] dat, output logic [DAT_W-1:0] rdat,
                     output bit ok);
    int n;
    begin
      ok   = 1'b0;
      rdat = '0;
      @(posedge core_clk);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hf;
      wb_dat_o <= dat;
      // Bound covers a full 256-clock midline wait with margin
      for (n = 0; n < 4000 && !ok; n++)
      begin
        @(posedge core_clk);
        if (wb_ack_i === 1'b1)
        begin
          ok   = 1'b1;
          rdat = wb_dat_i;
        end
      end
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
    end
  endtask : bus
  // Handler reloads the count for the next level before more loads
  task automatic load_level(input int lines);
    lines_left = lines;
    level_irq <= 1'b0;
  endtask : load_level
  // Exactly one row-load transfer at the end of a scan line
  task automatic scan_line(input logic [7:0] row, input logic [15:0] lvl_lum,
                           output bit ok);
    logic [DAT_W-1:0] r;
    begin
      bus(1'b1, {1'b1, row, 2'b00}, {16'h0000, lvl_lum}, r, ok);
      lines_left = lines_left - 1;
      // Count down once per line, interrupt on reaching zero
      if (lines_left == 0)
        level_irq <= 1'b1;
    end
  endtask : scan_line
endmodule : vrls_dma_model
`default_nettype wire

// ===== test/vrls_row_load_seq_tb_top.sv
// Self-checking bench for the row load sequencer.
// Assumes the DMA model owns the bus; the bench drives shift clock and pixels.
`timescale 1ns/10ps
`default_nettype none
module vrls_row_load_seq_tb_top;
  import vrls_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0, rstn = 1'b0, sc = 1'b0, sc_run = 1'b0, irq;
  logic wb_cyc, wb_stb, wb_we, wb_ack, rls, trg, cbr, trg_prev = 1'b0, trg_before = 1'b0;
  logic [ADR_W-1:0] wb_adr;
  logic [SEL_W-1:0] wb_sel;
  logic [DAT_W-1:0] wb_wdat, wb_rdat, r;
  logic [15:0]      pix = 16'h0000;
  logic [7:0]       row_addr, col_addr, expo, lum, row_seen = 8'h00, base;
  logic [1:0]       vid, sc_div = 2'b00;
  int err_total = 0, comparisons = 0, rls_cnt = 0, ref_cnt = 0, sc_rises = 0, k, c0;
  bit ok;
  always #10 core_clk = ~core_clk;                 // 50 MHz
  vrls_row_load_seq vrls_row_load_seq_inst (.core_clk(core_clk), .rstn(rstn),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .serial_shift_clock(sc), .pixel_bytes(pix), .row_load_strobe(rls),
    .vram_transfer_strobe(trg), .cbr_refresh_strobe(cbr), .vram_row_addr(row_addr),
    .vram_col_addr(col_addr), .exposure_level(expo), .luminance_level(lum),
    .video_bits(vid));
  vrls_dma_model vrls_dma_model_inst (.core_clk(core_clk), .wb_cyc_o(wb_cyc),
    .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
    .wb_dat_o(wb_wdat), .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat), .level_irq(irq));
  // ----------------------------------------------------------------
  // Shift clock and strobe monitor
  // ----------------------------------------------------------------
  // Shift clock rises every fourth core cycle, and stands still when stopped
  always @(posedge core_clk)
  begin
    if (sc_run)
    begin
      sc_div <= sc_div + 2'd1;
      sc     <= sc_div[1];
      if (!sc && sc_div[1])
        sc_rises <= sc_rises + 1;
    end
  end
  // Records strobe order: transfer strobe must lead the row strobe
  always @(posedge core_clk)
  begin
    trg_prev <= trg;
    if (rls === 1'b1)
    begin
      rls_cnt    <= rls_cnt + 1;
      trg_before <= trg_prev;
      row_seen   <= row_addr;
    end
    if (cbr === 1'b1)
      ref_cnt <= ref_cnt + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Ends the run if a bus cycle never got its answer
  task automatic done(input bit okf);
    if (!okf)
    begin
      err_total++;
      tally_and_finish();
    end
    else
      @(negedge core_clk);               // Let the ack edge's updates land
  endtask : done
  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    vrls_dma_model_inst.bus(1'b1, a, d, r, ok);
    done(ok);
  endtask : wr
  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] exp);
    vrls_dma_model_inst.bus(1'b0, a, '0, r, ok);
    done(ok);
    chk(r, exp);
  endtask : rd
  // Row load then checks levels, row, column, strobe order and row strobe count
  task automatic row_load(input logic [7:0] row, input logic [15:0] ll);
    c0 = rls_cnt;
    wr({1'b1, row, 2'b00}, {16'h0000, ll});
    chk(rls_cnt, c0 + 1);
    chk(row_seen, row);
    chk(expo, ll[7:0]);
    chk(lum, ll[15:8]);
    chk({col_addr, 7'h00, trg_before}, {COL_ZERO, 8'h01});
  endtask : row_load
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk({expo, lum, row_addr, col_addr}, 32'h0);
    rd(OFS_STATUS, 32'h0);
    // Boundary rows and levels
    row_load(8'h00, 16'hff00);
    row_load(8'hff, 16'h00ff);
    row_load(8'ha6, 16'h5a3c);
    rd(OFS_STATUS, 32'h005a3ca6);
    // Channel model: two lines for one level, interrupt after the second
    vrls_dma_model_inst.load_level(2);
    vrls_dma_model_inst.scan_line(8'h10, 16'h1122, ok);
    done(ok);
    chk(irq, 1'b0);
    vrls_dma_model_inst.scan_line(8'h12, 16'h3344, ok);
    done(ok);
    chk({irq, expo, row_seen}, {1'b1, 8'h44, 8'h12});
    // Select 00: refresh only, no load
    c0 = rls_cnt;
    k  = ref_cnt;
    wr(OFS_TT_CYCLE, 32'h0);
    chk(rls_cnt, c0);
    chk(ref_cnt, k + 1);
    rd(OFS_TT_CYCLE, 32'h0);
    // First load with the shift clock still, then three midline loads
    base = 8'h5c;
    row_load(base, 16'h4080);
    sc_run <= 1'b1;
    k = sc_rises;
    for (int s = 1; s <= 3; s++)
    begin
      c0 = rls_cnt;
      wr(OFS_TT_CYCLE, s);
      chk(sc_rises - k, 256 * s);
      chk(rls_cnt, c0 + 1);
      chk(trg_before, 1'b1);
      chk(row_seen, (s == 1) ? {base[7:1], 1'b1} : {base[7:2], s[1:0]});
    end
    chk(col_addr, COL_ZERO);
    // Comparator against exposure level 0x80
    for (int p = 0; p < 4; p++)
    begin
      @(posedge core_clk);
      pix <= (p == 0) ? 16'h807f : (p == 1) ? 16'hff00 : (p == 2) ? 16'h8180 : 16'h007f;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk(vid, (p == 0) ? 2'b10 : (p == 1) ? 2'b10 : (p == 2) ? 2'b11 : 2'b00);
    end
    sc_run <= 1'b0;
    // Unmapped place answers with zero and ignores writes
    wr(11'h008, 32'hffff_ffff);
    rd(11'h008, 32'h0);
    // Counter kept running mod 256 since the last row load restarted it
    rd(OFS_STATUS, {8'(sc_rises - k), 8'h40, 8'h80, base});
    tally_and_finish();
  end
endmodule : vrls_row_load_seq_tb_top
`default_nettype wire
